// ===== inc/adc_trig_pkg.sv
// shared constants and types for the converter trigger and monitor block
package adc_trig_pkg;
  localparam int ADDR_W = 8;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_TRIG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_MON0_CFG = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CMP0 = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CLK_SET = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h14;
  // trigger control field positions
  localparam int POS_PRIO_SRC = 7;
  localparam int POS_PRIO_EN = 6;
  localparam int POS_NORM_SRC = 5;
  localparam int POS_NORM_EN = 4;
  // monitor config field positions
  localparam int POS_MON_DIR = 5;
  localparam int POS_MON_SEL = 1;
  localparam int POS_MON_EN = 0;
  // soft reset key sequence
  localparam logic [1:0] KEY_FIRST = 2'h2;
  localparam logic [1:0] KEY_SECOND = 2'h1;
  // result field position in a result word
  localparam int POS_RESULT = 6;
  localparam int RES_W = 10;
  localparam int CLK_SET_W = 4;
  localparam logic [CLK_SET_W-1:0] CLK_SET_RST = 4'h0;
  localparam logic [7:0] TRIG_CTRL_RST = 8'h00;
  localparam logic [7:0] MON0_CFG_RST = 8'h00;
  localparam logic [RES_W-1:0] CMP0_RST = 10'h000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // irq status bit positions
  localparam int IRQ_MON0 = 0;
  localparam int IRQ_SRST = 1;
  localparam int IRQ_W = 2;

  typedef struct packed {
    logic prio_trig_source_sel;
    logic prio_hw_trig_enable;
    logic norm_trig_source_sel;
    logic norm_hw_trig_enable;
  } trig_cfg_t;

  typedef struct packed {
    logic monitor0_direction;
    logic [3:0] monitor0_target_sel;
    logic monitor0_enable;
  } mon_cfg_t;

  typedef enum logic [1:0] {
    KEY_IDLE = 2'b01,
    KEY_ARMED = 2'b10
  } key_state_t;
endpackage : adc_trig_pkg

// ===== rtl/adc_trigger_and_monitor_config.sv
// converter trigger routing, keyed soft reset and monitor 0 with axi4-lite
`timescale 1ns/100ps
module adc_trigger_and_monitor_config
  import adc_trig_pkg::*;
#(
  parameter int NUM_RES = 8
) (
  input wire logic mclk, // 125 MHz clock
  input wire logic rst_n, // async reset, active low
  input wire logic clk_en, // freezes all state when low
  input wire logic [ADDR_W-1:0] s_awaddr, // write address
  input wire logic s_awvalid, // write address valid
  output logic s_awready, // write address ready
  input wire logic [31:0] s_wdata, // write data
  input wire logic [3:0] s_wstrb, // write strobes
  input wire logic s_wvalid, // write data valid
  output logic s_wready, // write data ready
  output logic [1:0] s_bresp, // write response
  output logic s_bvalid, // write response valid
  input wire logic s_bready, // write response ready
  input wire logic [ADDR_W-1:0] s_araddr, // read address
  input wire logic s_arvalid, // read address valid
  output logic s_arready, // read address ready
  output logic [31:0] s_rdata, // read data
  output logic [1:0] s_rresp, // read response
  output logic s_rvalid, // read valid
  input wire logic s_rready, // read ready
  input wire logic ext_trig, // external trigger event pulse
  input wire logic timer_a_match, // timer a compare match pulse
  input wire logic timer_b_match, // timer b compare match pulse
  input wire logic [NUM_RES-1:0] res_store, // normal result stored pulses
  input wire logic [NUM_RES*16-1:0] res_words, // normal result words
  input wire logic prio_store, // priority result stored pulse
  input wire logic [15:0] prio_word, // priority result word
  output logic prio_hw_start, // top-priority hw start pulse
  output logic norm_hw_start, // normal hw start pulse
  output logic soft_reset, // converter soft reset pulse
  output logic mon0_irq_pulse, // monitor 0 request pulse
  output logic [CLK_SET_W-1:0] conv_clock_setting, // conversion clock
  output logic irq // level interrupt
);
  trig_cfg_t trig_ff, nxt_trig;
  mon_cfg_t mon_ff, nxt_mon;
  logic [RES_W-1:0] cmp0_ff, nxt_cmp0;
  logic [CLK_SET_W-1:0] clk_ff, nxt_clk;
  logic [IRQ_W-1:0] stat_ff, nxt_stat, mask_ff, nxt_mask;
  key_state_t key_ff, nxt_key;
  logic srst_ff, nxt_srst, st0_ff, nxt_st0;
  logic mon_ff_pulse, nxt_mon_pulse;
  logic prio_ff, nxt_prio, norm_ff, nxt_norm;
  logic aw_ff, nxt_aw, w_ff, nxt_w, b_ff, nxt_b, r_ff, nxt_r;
  logic [ADDR_W-1:0] awa_ff, nxt_awa;
  logic [31:0] wd_ff, nxt_wd, rd_ff, nxt_rd;
  logic [1:0] br_ff, nxt_br, rr_ff, nxt_rr;
  logic [RES_W-1:0] res_val [NUM_RES];
  logic [RES_W-1:0] sel_val;
  logic sel_store, hit, do_wr, do_rd, prio_src, norm_src;

  // result field extraction per channel
  genvar gi;
  generate
    for (gi = 0; gi < NUM_RES; gi++) begin : g_res
      assign res_val[gi] = res_words[gi*16+POS_RESULT +: RES_W];
    end
  endgenerate

  always_comb begin
    sel_val = prio_word[POS_RESULT +: RES_W];
    sel_store = prio_store;
    if (!mon_ff.monitor0_target_sel[3]) begin
      sel_val = res_val[mon_ff.monitor0_target_sel[2:0]];
      sel_store = res_store[mon_ff.monitor0_target_sel[2:0]];
    end
  end

  always_comb begin
    if (mon_ff.monitor0_direction)
      hit = sel_val > cmp0_ff;
    else
      hit = sel_val < cmp0_ff;
  end

  assign prio_src = trig_ff.prio_trig_source_sel ? timer_a_match : ext_trig;
  assign norm_src = trig_ff.norm_trig_source_sel ? timer_b_match : ext_trig;

  assign do_wr = aw_ff && w_ff && !b_ff;
  assign do_rd = s_arvalid && s_arready;
  assign s_awready = !aw_ff && !b_ff;
  assign s_wready = !w_ff && !b_ff;
  assign s_arready = !r_ff;

  always_comb begin
    nxt_aw = aw_ff;
    nxt_w = w_ff;
    nxt_b = b_ff;
    nxt_awa = awa_ff;
    nxt_wd = wd_ff;
    nxt_br = br_ff;
    nxt_r = r_ff;
    nxt_rd = rd_ff;
    nxt_rr = rr_ff;
    nxt_trig = trig_ff;
    nxt_mon = mon_ff;
    nxt_cmp0 = cmp0_ff;
    nxt_clk = clk_ff;
    nxt_mask = mask_ff;
    nxt_stat = stat_ff;
    nxt_key = key_ff;
    nxt_srst = 1'b0;
    nxt_prio = trig_ff.prio_hw_trig_enable && prio_src;
    // normal gating, ext trig reserved for prio when prio is enabled on ext
    nxt_norm = trig_ff.norm_hw_trig_enable && norm_src &&
      !(!trig_ff.norm_trig_source_sel && !trig_ff.prio_trig_source_sel &&
        trig_ff.prio_hw_trig_enable);
    nxt_mon_pulse = mon_ff.monitor0_enable && sel_store && hit;
    if (s_awvalid && s_awready) begin
      nxt_aw = 1'b1;
      nxt_awa = s_awaddr;
    end
    if (s_wvalid && s_wready) begin
      nxt_w = 1'b1;
      nxt_wd = s_wdata;
    end
    if (do_wr) begin
      nxt_aw = 1'b0;
      nxt_w = 1'b0;
      nxt_b = 1'b1;
      nxt_br = RESP_OKAY;
      case (awa_ff)
        OFS_TRIG_CTRL: begin
          if (st0_ff) begin
            nxt_trig = trig_cfg_t'(wd_ff[POS_NORM_EN +: 4]);
            if (key_ff == KEY_ARMED && wd_ff[1:0] == KEY_SECOND) begin
              nxt_srst = 1'b1;
              nxt_key = KEY_IDLE;
            end else if (wd_ff[1:0] == KEY_FIRST) begin
              nxt_key = KEY_ARMED;
            end else begin
              nxt_key = KEY_IDLE;
            end
          end
        end
        OFS_MON0_CFG: if (st0_ff) nxt_mon = mon_cfg_t'(wd_ff[5:0]);
        OFS_CMP0: nxt_cmp0 = wd_ff[RES_W-1:0];
        OFS_CLK_SET: nxt_clk = wd_ff[CLK_SET_W-1:0];
        OFS_IRQ_STAT: nxt_stat = stat_ff & ~wd_ff[IRQ_W-1:0];
        OFS_IRQ_MASK: nxt_mask = wd_ff[IRQ_W-1:0];
        default: nxt_br = RESP_SLVERR;
      endcase
    end
    if (b_ff && s_bready) nxt_b = 1'b0;
    // soft reset clears all but clock setting
    if (srst_ff) begin
      nxt_trig = trig_cfg_t'(TRIG_CTRL_RST[7:4]);
      nxt_mon = mon_cfg_t'(MON0_CFG_RST[5:0]);
      nxt_cmp0 = CMP0_RST;
      nxt_mask = '0;
      nxt_stat = '0;
    end
    // sticky set wins over clear
    if (mon_ff_pulse) nxt_stat[IRQ_MON0] = 1'b1;
    if (srst_ff) nxt_stat[IRQ_SRST] = 1'b1;
    if (do_rd) begin
      nxt_r = 1'b1;
      nxt_rr = RESP_OKAY;
      nxt_rd = 32'h0000_0000;
      case (s_araddr)
        OFS_TRIG_CTRL: nxt_rd[7:4] = trig_ff;
        OFS_MON0_CFG: nxt_rd[5:0] = mon_ff;
        OFS_CMP0: nxt_rd[RES_W-1:0] = cmp0_ff;
        OFS_CLK_SET: nxt_rd[CLK_SET_W-1:0] = clk_ff;
        OFS_IRQ_STAT: nxt_rd[IRQ_W-1:0] = stat_ff;
        OFS_IRQ_MASK: nxt_rd[IRQ_W-1:0] = mask_ff;
        default: nxt_rr = RESP_SLVERR;
      endcase
    end else if (r_ff && s_rready) begin
      nxt_r = 1'b0;
    end
  end

  always_comb begin
    nxt_st0 = st0_ff;
    if (s_wvalid && s_wready) nxt_st0 = s_wstrb[0];
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trig_ff <= trig_cfg_t'(TRIG_CTRL_RST[7:4]);
      mon_ff <= mon_cfg_t'(MON0_CFG_RST[5:0]);
      cmp0_ff <= CMP0_RST;
      clk_ff <= CLK_SET_RST;
      stat_ff <= '0;
      mask_ff <= '0;
      key_ff <= KEY_IDLE;
      srst_ff <= 1'b0;
      mon_ff_pulse <= 1'b0;
      prio_ff <= 1'b0;
      norm_ff <= 1'b0;
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      b_ff <= 1'b0;
      r_ff <= 1'b0;
      awa_ff <= '0;
      wd_ff <= '0;
      rd_ff <= '0;
      br_ff <= RESP_OKAY;
      rr_ff <= RESP_OKAY;
      st0_ff <= 1'b0;
    end else if (clk_en) begin
      trig_ff <= nxt_trig;
      mon_ff <= nxt_mon;
      cmp0_ff <= nxt_cmp0;
      clk_ff <= nxt_clk;
      stat_ff <= nxt_stat;
      mask_ff <= nxt_mask;
      key_ff <= nxt_key;
      srst_ff <= nxt_srst;
      mon_ff_pulse <= nxt_mon_pulse;
      prio_ff <= nxt_prio;
      norm_ff <= nxt_norm;
      aw_ff <= nxt_aw;
      w_ff <= nxt_w;
      b_ff <= nxt_b;
      r_ff <= nxt_r;
      awa_ff <= nxt_awa;
      wd_ff <= nxt_wd;
      rd_ff <= nxt_rd;
      br_ff <= nxt_br;
      rr_ff <= nxt_rr;
      st0_ff <= nxt_st0;
    end
  end

  assign s_bvalid = b_ff;
  assign s_bresp = br_ff;
  assign s_rvalid = r_ff;
  assign s_rdata = rd_ff;
  assign s_rresp = rr_ff;
  assign prio_hw_start = prio_ff;
  assign norm_hw_start = norm_ff;
  assign soft_reset = srst_ff;
  assign mon0_irq_pulse = mon_ff_pulse;
  assign conv_clock_setting = clk_ff;
  assign irq = |(stat_ff & mask_ff);

  // assertions
  property p_prio_route;
    @(posedge mclk) disable iff (!rst_n)
    clk_en && trig_ff.prio_hw_trig_enable && trig_ff.prio_trig_source_sel &&
      timer_a_match |=> prio_hw_start;
  endproperty
  a_prio_route: assert property (p_prio_route)
    else $error("timer a match did not start prio");
  property p_prio_block;
    @(posedge mclk) disable iff (!rst_n)
    clk_en && !trig_ff.prio_hw_trig_enable |=> !prio_hw_start;
  endproperty
  a_prio_block: assert property (p_prio_block)
    else $error("prio start while disabled");
  property p_norm_route;
    @(posedge mclk) disable iff (!rst_n)
    clk_en && trig_ff.norm_hw_trig_enable && trig_ff.norm_trig_source_sel &&
      timer_b_match |=> norm_hw_start;
  endproperty
  a_norm_route: assert property (p_norm_route)
    else $error("timer b match did not start normal");
  property p_norm_block;
    @(posedge mclk) disable iff (!rst_n)
    clk_en && !trig_ff.norm_hw_trig_enable |=> !norm_hw_start;
  endproperty
  a_norm_block: assert property (p_norm_block)
    else $error("normal start while disabled");
  property p_key;
    @(posedge mclk) disable iff (!rst_n)
    $rose(soft_reset) |-> $past(key_ff) == KEY_ARMED;
  endproperty
  a_key: assert property (p_key)
    else $error("soft reset without armed key");
  property p_srst_clear;
    @(posedge mclk) disable iff (!rst_n)
    soft_reset && clk_en |=> trig_ff == '0 && mon_ff == '0 &&
      clk_ff == $past(clk_ff);
  endproperty
  a_srst_clear: assert property (p_srst_clear)
    else $error("soft reset did not clear correctly");
  property p_ext_excl;
    @(posedge mclk) disable iff (!rst_n)
    clk_en && !trig_ff.prio_trig_source_sel && trig_ff.prio_hw_trig_enable
      && !trig_ff.norm_trig_source_sel |=> !norm_hw_start;
  endproperty
  a_ext_excl: assert property (p_ext_excl)
    else $error("ext trigger started both kinds");
  property p_mon_off;
    @(posedge mclk) disable iff (!rst_n)
    clk_en && !mon_ff.monitor0_enable |=> !mon0_irq_pulse;
  endproperty
  a_mon_off: assert property (p_mon_off)
    else $error("monitor pulse while disabled");
  property p_mon_dir;
    @(posedge mclk) disable iff (!rst_n)
    mon0_irq_pulse && $past(clk_en) |-> $past(mon_ff.monitor0_direction) ?
      $past(sel_val) > $past(cmp0_ff) : $past(sel_val) < $past(cmp0_ff);
  endproperty
  a_mon_dir: assert property (p_mon_dir)
    else $error("monitor pulse with wrong relation");
  property p_mon_one;
    @(posedge mclk) disable iff (!rst_n)
    mon0_irq_pulse && $past(clk_en) |-> $past(sel_store);
  endproperty
  a_mon_one: assert property (p_mon_one)
    else $error("monitor pulse without a store");
  c_srst: cover property (@(posedge mclk) soft_reset);
  c_mon: cover property (@(posedge mclk) mon0_irq_pulse);
  c_prio: cover property (@(posedge mclk) prio_hw_start);
  c_irq: cover property (@(posedge mclk) irq);
endmodule : adc_trigger_and_monitor_config

// ===== test/adc_trigger_and_monitor_config_test.sv
// self-checking bench for the converter trigger and monitor block
`timescale 1ns/100ps
module adc_trigger_and_monitor_config_test;
  import adc_trig_pkg::*;
  logic mclk = 1'h0;
  logic rst_n = 1'h0;
  logic clk_en = 1'h1;
  logic [ADDR_W-1:0] s_awaddr = '0, s_araddr = '0;
  logic s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0;
  logic s_arvalid = 1'h0, s_rready = 1'h0;
  logic [31:0] s_wdata = '0;
  logic [3:0] s_wstrb = '0;
  logic ext_trig = 1'h0, timer_a_match = 1'h0, timer_b_match = 1'h0;
  logic prio_store = 1'h0;
  logic [7:0] res_store = '0;
  logic [127:0] res_words = '0;
  logic [15:0] prio_word = '0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq;
  logic prio_hw_start, norm_hw_start, soft_reset, mon0_irq_pulse;
  logic [1:0] s_bresp, s_rresp, rsp;
  logic [31:0] s_rdata, rdat;
  logic [CLK_SET_W-1:0] conv_clock_setting;
  int fails = 0, compares = 0, srst_cnt = 0;
  // trigger rows: config nibble, events ext/ta/tb, expected prio/norm
  localparam logic [11:0] ROWS [10] = '{12'hc22, 12'hc40, 12'h820,
    12'h311, 12'h320, 12'h210, 12'h442, 12'h141, 12'h542, 12'h711};

  adc_trigger_and_monitor_config dut (.mclk, .rst_n, .clk_en, .s_awaddr,
    .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready,
    .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
    .s_rdata, .s_rresp, .s_rvalid, .s_rready, .ext_trig, .timer_a_match,
    .timer_b_match, .res_store, .res_words, .prio_store, .prio_word,
    .prio_hw_start, .norm_hw_start, .soft_reset, .mon0_irq_pulse,
    .conv_clock_setting, .irq);

  always #4 mclk = ~mclk;
  always @(negedge mclk) if (soft_reset === 1'h1) srst_cnt++;

  task report_and_stop;
    if (fails == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  task check(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : check

  task axi_wr(input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] r);
    logic pa, pw, ka, kw;
    pa = 1'h1;
    pw = 1'h1;
    @(posedge mclk);
    s_awaddr <= a;
    s_awvalid <= 1'h1;
    s_wdata <= d;
    s_wstrb <= 4'hf;
    s_wvalid <= 1'h1;
    s_bready <= 1'h1;
    while (pa || pw) begin
      @(negedge mclk);
      ka = pa && s_awready === 1'h1;
      kw = pw && s_wready === 1'h1;
      @(posedge mclk);
      if (ka) begin
        s_awvalid <= 1'h0;
        pa = 1'h0;
      end
      if (kw) begin
        s_wvalid <= 1'h0;
        pw = 1'h0;
      end
    end
    do @(negedge mclk); while (s_bvalid !== 1'h1);
    r = s_bresp;
    @(posedge mclk);
    s_bready <= 1'h0;
    #1;
  endtask : axi_wr

  task axi_rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
    @(posedge mclk);
    s_araddr <= a;
    s_arvalid <= 1'h1;
    s_rready <= 1'h1;
    do @(negedge mclk); while (s_arready !== 1'h1);
    @(posedge mclk);
    s_arvalid <= 1'h0;
    do @(negedge mclk); while (s_rvalid !== 1'h1);
    d = s_rdata;
    r = s_rresp;
    @(posedge mclk);
    s_rready <= 1'h0;
  endtask : axi_rd

  // store a result and expect a single request pulse or none
  task mst(input int idx, input logic [9:0] v, input logic e);
    @(posedge mclk);
    if (idx == 8) begin
      prio_word <= {v, 6'h3f};
      prio_store <= 1'h1;
    end else begin
      res_words[idx*16 +: 16] <= {v, 6'h3f};
      res_store <= 8'h01 << idx;
    end
    @(posedge mclk);
    prio_store <= 1'h0;
    res_store <= 8'h00;
    #1 check("mon0_irq_pulse", {31'h0, e}, {31'h0, mon0_irq_pulse});
    @(posedge mclk);
    #1 check("mon0_irq_pulse", 32'h0, {31'h0, mon0_irq_pulse});
  endtask : mst

  initial begin
    #200000;
    fails++;
    report_and_stop();
  end

  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'h1;
    for (int i = 0; i < 6; i++) begin
      axi_rd(8'(i * 4), rdat, rsp);
      check("reset value", 32'h0, rdat);
    end
    foreach (ROWS[i]) begin
      axi_wr(OFS_TRIG_CTRL, {24'h0, ROWS[i][11:8], 4'h0}, rsp);
      @(posedge mclk);
      ext_trig <= ROWS[i][6];
      timer_a_match <= ROWS[i][5];
      timer_b_match <= ROWS[i][4];
      @(posedge mclk);
      ext_trig <= 1'h0;
      timer_a_match <= 1'h0;
      timer_b_match <= 1'h0;
      #1 check("hw_start", {30'h0, ROWS[i][1:0]},
        {30'h0, prio_hw_start, norm_hw_start});
      @(posedge mclk);
      #1 check("hw_start", 32'h0, {30'h0, prio_hw_start, norm_hw_start});
    end
    axi_wr(OFS_CMP0, 32'h100, rsp);
    axi_wr(OFS_IRQ_MASK, 32'h1, rsp);
    axi_wr(OFS_MON0_CFG, 32'h27, rsp);
    mst(3, 10'h101, 1'h1);
    check("irq", 32'h1, {31'h0, irq});
    mst(3, 10'h100, 1'h0);
    mst(2, 10'h3ff, 1'h0);
    axi_wr(OFS_MON0_CFG, 32'h07, rsp);
    mst(3, 10'h0ff, 1'h1);
    mst(3, 10'h101, 1'h0);
    axi_wr(OFS_MON0_CFG, 32'h1f, rsp);
    mst(8, 10'h000, 1'h1);
    mst(7, 10'h000, 1'h0);
    axi_wr(OFS_MON0_CFG, 32'h1e, rsp);
    mst(8, 10'h000, 1'h0);
    axi_rd(OFS_IRQ_STAT, rdat, rsp);
    check("irq_status", 32'h1, rdat);
    axi_wr(OFS_IRQ_MASK, 32'h0, rsp);
    check("irq masked", 32'h0, {31'h0, irq});
    axi_wr(OFS_IRQ_MASK, 32'h1, rsp);
    check("irq unmasked", 32'h1, {31'h0, irq});
    axi_wr(OFS_IRQ_STAT, 32'h1, rsp);
    check("irq cleared", 32'h0, {31'h0, irq});
    axi_wr(OFS_MON0_CFG, 32'hffffffff, rsp);
    axi_rd(OFS_MON0_CFG, rdat, rsp);
    check("mon0 cfg", 32'h3f, rdat);
    axi_wr(OFS_CLK_SET, 32'h5, rsp);
    axi_wr(OFS_TRIG_CTRL, 32'hf2, rsp);
    axi_rd(OFS_TRIG_CTRL, rdat, rsp);
    check("trig ctrl", 32'hf0, rdat);
    axi_wr(OFS_TRIG_CTRL, 32'hf0, rsp);
    axi_wr(OFS_TRIG_CTRL, 32'hf1, rsp);
    repeat (3) @(posedge mclk);
    check("soft reset count", 32'h0, 32'(srst_cnt));
    axi_wr(OFS_TRIG_CTRL, 32'hf2, rsp);
    axi_wr(OFS_TRIG_CTRL, 32'hf1, rsp);
    repeat (3) @(posedge mclk);
    check("soft reset count", 32'h1, 32'(srst_cnt));
    for (int i = 0; i < 4; i++) begin
      axi_rd(8'(i * 4), rdat, rsp);
      check("after soft reset", (i == 3) ? 32'h5 : 32'h0, rdat);
    end
    axi_rd(OFS_IRQ_MASK, rdat, rsp);
    check("mask after soft reset", 32'h0, rdat);
    check("conv_clock_setting", 32'h5, {28'h0, conv_clock_setting});
    axi_rd(OFS_IRQ_STAT, rdat, rsp);
    check("irq_status", 32'h2, rdat);
    // both sources on timer matches, ext trigger must do nothing
    axi_wr(OFS_TRIG_CTRL, 32'hf0, rsp);
    @(posedge mclk);
    ext_trig <= 1'h1;
    @(posedge mclk);
    ext_trig <= 1'h0;
    clk_en <= 1'h0;
    timer_a_match <= 1'h1;
    #1 check("ext ignored", 32'h0, {30'h0, prio_hw_start, norm_hw_start});
    @(posedge mclk);
    timer_a_match <= 1'h0;
    clk_en <= 1'h1;
    #1 check("frozen prio_hw_start", 32'h0, {31'h0, prio_hw_start});
    axi_rd(8'h20, rdat, rsp);
    check("unmapped rdata", 32'h0, rdat);
    check("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    axi_wr(8'h20, 32'h1, rsp);
    check("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    // system reset in mid-run clears config and clock setting
    axi_wr(OFS_MON0_CFG, 32'h3f, rsp);
    @(posedge mclk);
    rst_n <= 1'h0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'h1;
    axi_rd(OFS_MON0_CFG, rdat, rsp);
    check("mon0 cfg after reset", 32'h0, rdat);
    axi_rd(OFS_CLK_SET, rdat, rsp);
    check("clock after reset", 32'h0, rdat);
    report_and_stop();
  end
endmodule : adc_trigger_and_monitor_config_test
